// file: common/led_current_regs.svh
// constants of the serial current-setting block
// assumes a 40 MHz reference clock; included by the package and the design module
`ifndef LED_CURRENT_REGS_SVH
`define LED_CURRENT_REGS_SVH

// ----------------------------------------
// widths and counts
// ----------------------------------------
`define SETTING_BITS        7
`define OVERFLOW_PULSES     8
`define PULSE_CNT_BITS      4

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_PS       25000
`define CLEAR_PULSE_PS      20000
// longest time, round down, at least one cycle
`define CLEAR_PULSE_CYCLES  ((`CLEAR_PULSE_PS / `CLK_PERIOD_PS) < 1 ? 1 : \
                             (`CLEAR_PULSE_PS / `CLK_PERIOD_PS))

// ----------------------------------------
// reset values
// ----------------------------------------
`define SETTING_RESET       7'h00

`endif

// file: common/led_current_pkg.sv
// types of the serial current-setting block
// assumes led_current_regs.svh on the include path
`include "led_current_regs.svh"

package led_current_pkg;

    // ----------------------------------------
    // operating state
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_SHUTDOWN,
        ST_SELECTED,
        ST_OVERFLOW
    } op_state_e;

    typedef logic [`SETTING_BITS-1:0] setting_t;

endpackage : led_current_pkg

// file: hdl/led_current_serial_setting.sv
// serial current-setting logic of a backlight led boost driver
// assumes select and clock pins come from outside ref_clk and are synchronised here
`timescale 1ns/1ps
`include "led_current_regs.svh"

// What this block does
// - clocks accepted only while select low
// - select falling edge clears shift register
// - open select reads high, device disabled in local mode
// - each clock shifts preset one in
// - clock edges counted only inside select window
// - no readback, no overflow guard
// - over eight clocks: clear, zero, shutdown
// - select rising edge latches setting
// - mode high: serial programmed current
// - mode low: select on/off, base current
// - seven bits cleared; current by lowest set bit
module led_current_serial_setting
    import led_current_pkg::*;
#(
    parameter int SETTING_BITS = `SETTING_BITS,
    parameter int OVERFLOW_PULSES = `OVERFLOW_PULSES
) (
    // clock, reset, enable
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic                    clk_en,
    // host pins; pad pull-ups make an open pin read high
    input  wire logic                    select_n,
    input  wire logic                    shift_clock,
    input  wire logic                    mode_remote,
    // current level to the analog mirror
    output logic                         output_enable,
    output logic [3:0]                   current_level,
    output logic                         base_current,
    output logic [SETTING_BITS-1:0]      active_setting
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [2:0]                  sel_sync;
        logic [2:0]                  clk_sync;
        logic [2:0]                  mode_sync;
        logic                        sel_q;
        logic                        clk_q;
        logic                        mode_q;
        op_state_e                   state;
        logic [SETTING_BITS-1:0]     shift;
        logic [SETTING_BITS-1:0]     latched;
        logic [`PULSE_CNT_BITS-1:0]  pulses;
        logic                        en;
        logic [3:0]                  level;
        logic                        base;
    } core_s;

    core_s core_r;
    core_s core_nxt;

    logic sel_fall;
    logic sel_rise;
    logic clk_rise;

    // ----------------------------------------
    // pin filtering and edges
    // ----------------------------------------
    // a change counts once stages two and three agree, filtering a one-cycle glitch
    always_comb begin
        core_nxt = core_r;
        core_nxt.sel_sync = {core_r.sel_sync[1:0], select_n};
        core_nxt.clk_sync = {core_r.clk_sync[1:0], shift_clock};
        core_nxt.mode_sync = {core_r.mode_sync[1:0], mode_remote};
        if (core_r.sel_sync[1] == core_r.sel_sync[2]) begin
            core_nxt.sel_q = core_r.sel_sync[2];
        end
        if (core_r.clk_sync[1] == core_r.clk_sync[2]) begin
            core_nxt.clk_q = core_r.clk_sync[2];
        end
        if (core_r.mode_sync[1] == core_r.mode_sync[2]) begin
            core_nxt.mode_q = core_r.mode_sync[2];
        end
        sel_fall = core_r.sel_q && !core_nxt.sel_q;
        sel_rise = !core_r.sel_q && core_nxt.sel_q;
        clk_rise = !core_r.clk_q && core_nxt.clk_q;

        // ----------------------------------------
        // sequencing
        // ----------------------------------------
        case (core_r.state)
            ST_SHUTDOWN: begin
                if (sel_fall) begin
                    core_nxt.shift = '0;
                    core_nxt.pulses = '0;
                    core_nxt.state = ST_SELECTED;
                end
            end
            ST_SELECTED: begin
                if (sel_rise) begin
                    core_nxt.latched = core_r.shift;
                    core_nxt.state = ST_SHUTDOWN;
                end else if (clk_rise && core_r.mode_q) begin
                    if (core_r.pulses == `PULSE_CNT_BITS'(OVERFLOW_PULSES)) begin
                        // ninth pulse: no saturation, the setting is lost
                        core_nxt.shift = '0;
                        core_nxt.latched = '0;
                        core_nxt.state = ST_OVERFLOW;
                    end else begin
                        core_nxt.pulses = core_r.pulses + `PULSE_CNT_BITS'(1);
                        // preset one enters at the top and moves right
                        core_nxt.shift = {1'b1, core_r.shift[SETTING_BITS-1:1]};
                    end
                end
            end
            ST_OVERFLOW: begin
                // stays off until the next select window
                if (sel_rise) begin
                    core_nxt.state = ST_SHUTDOWN;
                end
            end
            default: begin
                core_nxt.state = ST_SHUTDOWN;
            end
        endcase

        // ----------------------------------------
        // output current
        // ----------------------------------------
        // level n means reference_current * 746 * (n + 0.5)
        // ones fill from the top, so the lowest set bit gives the pulse count
        core_nxt.level = '0;
        for (int i = SETTING_BITS - 1; i >= 0; i--) begin
            if (core_nxt.latched[i]) begin
                core_nxt.level = 4'(SETTING_BITS - i);
            end
        end
        if (core_nxt.mode_q) begin
            core_nxt.en = (core_nxt.state != ST_OVERFLOW) && (core_nxt.level != '0);
            core_nxt.base = 1'b0;
        end else begin
            // clock ignored; select switches the base current, and a select window still clears the latched setting
            core_nxt.en = !core_nxt.sel_q;
            core_nxt.base = 1'b1;
            core_nxt.level = '0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // select and mode start high, as the pad pull-ups leave them
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            core_r <= '0;
            core_r.sel_sync <= 3'h7;
            core_r.mode_sync <= 3'h7;
            core_r.sel_q <= 1'b1;
            core_r.mode_q <= 1'b1;
            core_r.state <= ST_SHUTDOWN;
        end else if (clk_en) begin
            core_r <= core_nxt;
        end
    end

    // no path returns the setting to the host
    assign output_enable = core_r.en;
    assign current_level = core_r.level;
    assign base_current = core_r.base;
    assign active_setting = core_r.latched;

endmodule : led_current_serial_setting

// file: test/led_current_props.sv
// checker of the current-setting block
// assumes binding to the top module ports
`timescale 1ns/1ps
module led_current_props #(
    parameter int SETTING_BITS = 7
) (
    input wire logic                    ref_clk,
    input wire logic                    rst_n,
    input wire logic                    clk_en,
    input wire logic                    select_n,
    input wire logic                    shift_clock,
    input wire logic                    mode_remote,
    input wire logic                    output_enable,
    input wire logic [3:0]              current_level,
    input wire logic                    base_current,
    input wire logic [SETTING_BITS-1:0] active_setting
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // eight quiet cycles cover the pin filter latency
    sequence local_quiet;
        (!mode_remote && $stable(select_n))[*8];
    endsequence
    sequence remote_idle;
        (mode_remote && select_n)[*8];
    endsequence
    a_level_range: assert property (current_level <= 4'h7)
        else $error("level out of range");
    a_setting_shape: assert property (!base_current |->
        active_setting == ((7'h7F << (7 - current_level)) & 7'h7F)) else $error("bad shape");
    a_hold_idle: assert property (remote_idle |=> $stable(active_setting))
        else $error("setting moved outside window");
    a_local_base: assert property (local_quiet |-> base_current && current_level == 4'h0)
        else $error("local mode current wrong");
    a_local_enable: assert property (local_quiet |-> output_enable == !select_n)
        else $error("local on off wrong");
    a_remote_nobase: assert property (mode_remote [*8] |-> !base_current)
        else $error("base current in serial mode");
    a_level_enable: assert property (remote_idle |->
        output_enable == (current_level != 4'h0)) else $error("enable disagrees with level");
    a_latch_on_rise: assert property ((mode_remote && $changed(active_setting)
        && active_setting != 0) |-> select_n) else $error("latched while selected");
endmodule : led_current_props

bind led_current_serial_setting led_current_props #(.SETTING_BITS(SETTING_BITS)) led_current_props_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .select_n(select_n),
    .shift_clock(shift_clock), .mode_remote(mode_remote), .output_enable(output_enable),
    .current_level(current_level), .base_current(base_current),
    .active_setting(active_setting));

// file: test/host_model.sv
// host model driving select, clock and mode pins
// assumes tasks are entered on a falling clock edge
`timescale 1ns/1ps
module host_model (
    input wire logic ref_clk,
    output logic     select_n,
    output logic     shift_clock,
    output logic     mode_remote
);
    initial begin
        select_n = 1'b1; // pull-up idles high
        shift_clock = 1'b0;
        mode_remote = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : hold
    // four cycles a level, above the pin filter minimum
    task automatic pulse();
        shift_clock = 1'b1;
        hold(4);
        shift_clock = 1'b0;
        hold(4);
    endtask : pulse
    task automatic pins(input logic sel, input logic mode);
        select_n = sel;
        mode_remote = mode;
        hold(10);
    endtask : pins
    task automatic frame(input int k);
        select_n = 1'b0; // select before clocking
        hold(6);
        repeat (k) pulse(); // host counts its clocks
        select_n = 1'b1;
        hold(10);
    endtask : frame
endmodule : host_model

// file: test/led_current_serial_setting_test.sv
// bench of the current-setting block
// assumes host_model and the bound checker
`timescale 1ns/1ps
module led_current_serial_setting_test;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       clk_en = 1'b1;
    logic       select_n, shift_clock, mode_remote, output_enable, base_current;
    logic [3:0] current_level;
    logic [6:0] active_setting;
    int         fail_count = 0;
    int         n_tests = 0;
    always #12.5 ref_clk = ~ref_clk;
    host_model host_model_inst (.ref_clk(ref_clk), .select_n(select_n),
        .shift_clock(shift_clock), .mode_remote(mode_remote));
    led_current_serial_setting led_current_serial_setting_inst (.ref_clk(ref_clk),
        .rst_n(rst_n), .clk_en(clk_en), .select_n(select_n), .shift_clock(shift_clock),
        .mode_remote(mode_remote), .output_enable(output_enable),
        .current_level(current_level), .base_current(base_current),
        .active_setting(active_setting));
    task automatic check(input string name, input logic [6:0] seen, input logic [6:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    task automatic t_serial();
        for (int k = 0; k < 8; k++) begin
            host_model_inst.frame(k);
            check("setting", active_setting, 7'h7F << (7 - k));
            check("level", current_level, 7'(k));
            check("enable", output_enable, 7'(k != 0));
            check("base", base_current, 7'h00);
        end
        $display("serial done");
    endtask : t_serial
    task automatic t_outside();
        host_model_inst.frame(7);
        repeat (3) host_model_inst.pulse();
        check("idle clocks", active_setting, 7'h7F);
        host_model_inst.frame(2);
        check("cleared", active_setting, 7'h60);
        $display("outside done");
    endtask : t_outside
    task automatic t_overflow();
        host_model_inst.frame(9); // deliberate ninth clock
        check("ovf setting", active_setting, 7'h00);
        check("ovf level", current_level, 7'h00);
        check("ovf enable", output_enable, 7'h00);
        $display("overflow done");
    endtask : t_overflow
    task automatic t_local();
        host_model_inst.pins(1'b0, 1'b0);
        repeat (2) host_model_inst.pulse();
        check("local base", base_current, 7'h01);
        check("local on", output_enable, 7'h01);
        check("local level", current_level, 7'h00);
        host_model_inst.pins(1'b1, 1'b0);
        check("local off", output_enable, 7'h00);
        host_model_inst.pins(1'b1, 1'b1);
        $display("local done");
    endtask : t_local
    initial begin
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        check("reset", active_setting, 7'h00);
        t_serial();
        t_outside();
        t_overflow();
        t_local();
        summarize();
    end
    // all tests need under 2000 cycles
    initial begin
        #200us;
        fail_count++;
        summarize();
    end
endmodule : led_current_serial_setting_test
